// File: design/pmbfl_pkg.sv
package pmbfl_pkg;
    // Register set size and command codes
    localparam int         NREG       = 21;
    localparam logic [7:0] CMD_CLEAR  = 8'h03;
    localparam logic [7:0] CMD_SCALE  = 8'h29;
    localparam logic [7:0] CMD_UVW    = 8'h43;
    localparam logic [7:0] CMD_UVF    = 8'h44;
    localparam logic [7:0] CMD_UVA    = 8'h45;
    localparam logic [7:0] CMD_OCF    = 8'h46;
    localparam logic [7:0] CMD_OCA    = 8'h47;
    localparam logic [7:0] CMD_OCW    = 8'h4A;
    localparam logic [7:0] CMD_OTF    = 8'h4F;
    localparam logic [7:0] CMD_OTA    = 8'h50;
    localparam logic [7:0] CMD_OTW    = 8'h51;
    localparam logic [7:0] CMD_VIOF   = 8'h55;
    localparam logic [7:0] CMD_VIOA   = 8'h56;
    localparam logic [7:0] CMD_VIUW   = 8'h58;
    localparam logic [7:0] CMD_PGON   = 8'h5E;
    localparam logic [7:0] CMD_PGOFF  = 8'h5F;
    localparam logic [7:0] CMD_TDLY   = 8'h60;
    localparam logic [7:0] CMD_TRISE  = 8'h61;
    localparam logic [7:0] CMD_TMAX   = 8'h62;
    localparam logic [7:0] CMD_TMAXA  = 8'h63;
    localparam logic [7:0] CMD_TOFFD  = 8'h64;
    localparam logic [7:0] CMD_TOFFF  = 8'h65;

    // Storage index of each stored command except 64h and 65h, same order as REG_CODE
    localparam logic [4:0] I_SCALE = 5'h00, I_UVW  = 5'h01, I_UVF  = 5'h02;
    localparam logic [4:0] I_UVA   = 5'h03, I_OCF  = 5'h04, I_OCA  = 5'h05;
    localparam logic [4:0] I_OCW   = 5'h06, I_OTF  = 5'h07, I_OTA  = 5'h08;
    localparam logic [4:0] I_OTW   = 5'h09, I_VIOF = 5'h0A, I_VIOA = 5'h0B;
    localparam logic [4:0] I_VIUW  = 5'h0C, I_PGON = 5'h0D, I_PGOF = 5'h0E;
    localparam logic [4:0] I_TDLY  = 5'h0F, I_TRIS = 5'h10, I_TMAX = 5'h11;
    localparam logic [4:0] I_TMXA  = 5'h12;

    localparam logic [7:0] REG_CODE [NREG] = '{CMD_SCALE, CMD_UVW, CMD_UVF,
        CMD_UVA, CMD_OCF, CMD_OCA, CMD_OCW, CMD_OTF, CMD_OTA, CMD_OTW,
        CMD_VIOF, CMD_VIOA, CMD_VIUW, CMD_PGON, CMD_PGOFF, CMD_TDLY,
        CMD_TRISE, CMD_TMAX, CMD_TMAXA, CMD_TOFFD, CMD_TOFFF};

    // Value format: 16-bit mantissa, 5+11 exponent form, or one byte
    localparam logic [1:0] K_L16 = 2'h0, K_L11 = 2'h1, K_BYTE = 2'h2;
    localparam logic [1:0] REG_KIND [NREG] = '{K_L11, K_L16, K_L16, K_BYTE,
        K_L11, K_BYTE, K_L11, K_L11, K_BYTE, K_L11, K_L11, K_BYTE, K_L11,
        K_L16, K_L16, K_L11, K_L11, K_L11, K_BYTE, K_L11, K_L11};

    // Only exponent accepted for each five-bit exponent register
    localparam logic [4:0] EXP_0 = 5'h00, EXP_M1 = 5'h1F;
    localparam logic [4:0] EXP_M2 = 5'h1E, EXP_M3 = 5'h1D;
    localparam logic [4:0] REG_EXP [NREG] = '{EXP_M3, EXP_0, EXP_0, EXP_0,
        EXP_M1, EXP_0, EXP_M1, EXP_0, EXP_0, EXP_0, EXP_M2, EXP_0, EXP_M1,
        EXP_0, EXP_0, EXP_0, EXP_0, EXP_0, EXP_0, EXP_0, EXP_0};

    // Fault actions, held in bits 7:6 of an action byte
    localparam logic [1:0] ACT_IGNORE = 2'h0;
    localparam logic [1:0] ACT_SHUT   = 2'h2;
    localparam logic [1:0] ACT_INHIB  = 2'h3;
    localparam logic [7:0] RST_IGN    = 8'h00;
    localparam logic [7:0] RST_SHUT   = 8'h80;
    localparam logic [7:0] RST_INHIB  = 8'hC0;

    // Reset values; output levels in 1/256 V steps
    localparam logic [15:0] REG_RST [NREG] = '{16'hE808, 16'h0071, 16'h0065,
        {8'h00, RST_IGN}, 16'hF85C, {8'h00, RST_SHUT}, 16'hF84E, 16'h0091,
        {8'h00, RST_INHIB}, 16'h007D, 16'hF060, {8'h00, RST_SHUT}, 16'hF801,
        16'h0073, 16'h006C, 16'h0000, 16'h0002, 16'h0000, {8'h00, RST_IGN},
        16'h0000, 16'h0001};

    // Millisecond tick at the 250 MHz clock
    localparam int CLK_KHZ   = 250000;
    localparam int MS_TIME   = 1;
    localparam int MS_CYCLES = CLK_KHZ * MS_TIME;

    typedef enum logic [1:0] {SEQ_OFF, SEQ_DELAY, SEQ_RISE, SEQ_ON} pmbfl_seq_t;
endpackage

// File: design/pmbfl_limits.sv
`timescale 1ns/1ps
// How it works
// - Output-low warning level at 43h, 3.9mV steps, reset 0.44V, flags low.
// - Output under-voltage fault level at 44h, reset 0.395V, latches fault once regulating.
// - Under-voltage action byte at 45h, ignore or shutdown, reset ignore.
// - Over-current fault level at 46h, 0.5A steps, reset 46A, exponent -1.
// - Over-current action byte at 47h picks the reaction to that fault.
// - Over-temperature fault level at 4Fh, 1C steps, reset 145C, exponent 0.
// - Over-temperature action at 50h: ignore, shutdown or inhibit; reset inhibit.
// - Over-temperature warning level at 51h, reset 125C, raises warning.
// - Input over-voltage fault level at 55h, 0.25V steps, reset 24V.
// - Input over-voltage action at 56h, ignore or shutdown, reset shutdown.
// - Input-low warning level at 58h, 0.5V steps, reset 0.5V, exponent -1.
// - Power good asserts when output reaches level at 5Eh, reset 0.45V.
// - Power good negates when output falls to level at 5Fh, reset 0.42V.
// - Wait turn-on delay at 60h, 1ms steps, before the rise starts.
// - Ramp phase lasts the rise time at 61h, reset 2ms.
// - Turn-on timeout at 62h if output not above fault level; 0 disables.
// - Turn-on timeout action at 63h, ignore or shutdown, reset ignore.
// - Turn-off delay at 64h is stored but never applied.
// - Turn-off fall time at 65h is acknowledged and has no effect.
// - Output levels are divided by the loop scale at 29h: 1 to 0.125.
// - Clear-faults command 03h erases every latched fault.
module pmbfl_limits #(
    parameter int MS_CYCLES = pmbfl_pkg::MS_CYCLES
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Command port from the transaction layer
    input  wire logic        cmd_valid,
    input  wire logic        cmd_write,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [15:0] cmd_wdata,
    output logic             rsp_valid_q,
    output logic             rsp_ack_q,
    output logic [15:0]      rsp_data_q,
    // Telemetry samples, same clock
    input  wire logic        smp_valid,
    input  wire logic [15:0] vout_smp,
    input  wire logic [15:0] iout_smp,
    input  wire logic [15:0] temp_smp,
    input  wire logic [15:0] vin_smp,
    // Start condition and converter control
    input  wire logic        start_req,
    output logic             convert_en_q,
    output logic             ramp_q,
    output logic             power_good_q,
    // Live warnings and latched faults
    output logic [3:0]       warn_q,
    output logic [4:0]       fault_q
);
    logic [15:0]            regs_q [pmbfl_pkg::NREG];
    logic                   hit;
    logic [4:0]             idx;
    logic                   wr_ok;
    logic                   clr;
    logic [1:0]             shift;
    logic [18:0]            uvw_s, uvf_s, pgon_s, pgof_s, vout_w;
    logic [4:0]             ev;
    logic [4:0]             shut_mask;
    logic                   shut_q;
    logic                   ot_live_q;
    logic                   inhib;
    logic                   run_ok;
    logic                   reached_q;
    logic                   tmo_done_q;
    logic                   tick;
    logic [31:0]            div_q;
    logic [10:0]            ms_q, ton_ms_q;
    pmbfl_pkg::pmbfl_seq_t  st_q, st_d;

    // Command decode against the code table
    always_comb begin
        hit = 1'b0;
        idx = 5'h00;
        for (int i = 0; i < pmbfl_pkg::NREG; i++) begin
            if (pmbfl_pkg::REG_CODE[i] == cmd_code) begin
                hit = 1'b1;
                idx = 5'(i);
            end
        end
    end

    // Writes with a wrong exponent or scale are refused
    always_comb begin
        wr_ok = hit;
        if (pmbfl_pkg::REG_KIND[idx] == pmbfl_pkg::K_L11 &&
            cmd_wdata[15:11] != pmbfl_pkg::REG_EXP[idx])
            wr_ok = 1'b0;
        if (idx == pmbfl_pkg::I_SCALE && !(cmd_wdata[10:0] inside
            {11'h001, 11'h002, 11'h004, 11'h008}))
            wr_ok = 1'b0;
    end

    assign clr = cmd_valid && cmd_write && cmd_code == pmbfl_pkg::CMD_CLEAR;

    // Register store; turn-off settings are kept but never used
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < pmbfl_pkg::NREG; i++) begin
                regs_q[i] <= pmbfl_pkg::REG_RST[i];
            end
        end else if (cmd_valid && cmd_write && wr_ok) begin
            if (pmbfl_pkg::REG_KIND[idx] == pmbfl_pkg::K_BYTE) begin
                regs_q[idx] <= {8'h00, cmd_wdata[7:0]};
            end else begin
                regs_q[idx] <= cmd_wdata;
            end
        end
    end

    // One answer per command, next cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rsp_valid_q <= 1'b0;
            rsp_ack_q   <= 1'b0;
            rsp_data_q  <= 16'h0000;
        end else begin
            rsp_valid_q <= cmd_valid;
            rsp_ack_q   <= cmd_valid && (clr || (cmd_write ? wr_ok : hit));
            rsp_data_q  <= (cmd_valid && !cmd_write && hit) ?
                           regs_q[idx] : 16'h0000;
        end
    end

    // Output levels scaled up by 1/Vs into sensed-voltage units
    always_comb begin
        unique case (regs_q[pmbfl_pkg::I_SCALE][3:0])
            4'h8:    shift = 2'h0;
            4'h4:    shift = 2'h1;
            4'h2:    shift = 2'h2;
            default: shift = 2'h3;
        endcase
    end
    assign uvw_s  = {3'h0, regs_q[pmbfl_pkg::I_UVW]} << shift;
    assign uvf_s  = {3'h0, regs_q[pmbfl_pkg::I_UVF]} << shift;
    assign pgon_s = {3'h0, regs_q[pmbfl_pkg::I_PGON]} << shift;
    assign pgof_s = {3'h0, regs_q[pmbfl_pkg::I_PGOF]} << shift;
    assign vout_w = {3'h0, vout_smp};

    // Fault events from each fresh sample, timeout from the ms count; UV only once regulating
    always_comb begin
        ev = 5'h00;
        if (smp_valid) begin
            ev[0] = st_q == pmbfl_pkg::SEQ_ON && vout_w <= uvf_s;
            ev[1] = iout_smp[10:0] >= regs_q[pmbfl_pkg::I_OCF][10:0];
            ev[2] = temp_smp[10:0] >= regs_q[pmbfl_pkg::I_OTF][10:0];
            ev[3] = vin_smp[10:0] >= regs_q[pmbfl_pkg::I_VIOF][10:0];
        end
        ev[4] = !tmo_done_q && !reached_q &&
                regs_q[pmbfl_pkg::I_TMAX][10:0] != 11'h000 &&
                (st_q == pmbfl_pkg::SEQ_RISE || st_q == pmbfl_pkg::SEQ_ON) &&
                ton_ms_q >= regs_q[pmbfl_pkg::I_TMAX][10:0];
    end

    // Which faults are set to shut the converter down
    always_comb begin
        shut_mask[0] = regs_q[pmbfl_pkg::I_UVA][7:6] == pmbfl_pkg::ACT_SHUT;
        shut_mask[1] = regs_q[pmbfl_pkg::I_OCA][7:6] == pmbfl_pkg::ACT_SHUT;
        shut_mask[2] = regs_q[pmbfl_pkg::I_OTA][7:6] == pmbfl_pkg::ACT_SHUT;
        shut_mask[3] = regs_q[pmbfl_pkg::I_VIOA][7:6] == pmbfl_pkg::ACT_SHUT;
        shut_mask[4] = regs_q[pmbfl_pkg::I_TMXA][7:6] == pmbfl_pkg::ACT_SHUT;
    end

    // Latched faults; a new event beats a clear in the same cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fault_q <= 5'h00;
        end else begin
            fault_q <= (fault_q & {5{!clr}}) | ev;
        end
    end

    // Shutdown latch holds the converter off until a clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            shut_q <= 1'b0;
        end else begin
            shut_q <= (shut_q && !clr) || |(ev & shut_mask);
        end
    end

    // Inhibit only holds off while over-temperature persists
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ot_live_q <= 1'b0;
        end else if (smp_valid) begin
            ot_live_q <= temp_smp[10:0] >= regs_q[pmbfl_pkg::I_OTF][10:0];
        end
    end
    assign inhib  = ot_live_q &&
        regs_q[pmbfl_pkg::I_OTA][7:6] == pmbfl_pkg::ACT_INHIB;
    assign run_ok = start_req && !shut_q && !inhib;

    // Warnings follow each sample, not latched
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            warn_q <= 4'h0;
        end else if (smp_valid) begin
            warn_q[0] <= vout_w <= uvw_s;
            warn_q[1] <= iout_smp[10:0] >= regs_q[pmbfl_pkg::I_OCW][10:0];
            warn_q[2] <= temp_smp[10:0] >= regs_q[pmbfl_pkg::I_OTW][10:0];
            warn_q[3] <= {vin_smp[10:0], 1'b0} <=
                         {regs_q[pmbfl_pkg::I_VIUW][10:0], 1'b0} << 1;
        end
    end

    // Sequencer: off, delay, rise, regulate
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            pmbfl_pkg::SEQ_OFF: begin
                if (run_ok) begin
                    st_d = pmbfl_pkg::SEQ_DELAY;
                end
            end
            pmbfl_pkg::SEQ_DELAY: begin
                if (ms_q >= regs_q[pmbfl_pkg::I_TDLY][10:0]) begin
                    st_d = pmbfl_pkg::SEQ_RISE;
                end
            end
            pmbfl_pkg::SEQ_RISE: begin
                if (ms_q >= regs_q[pmbfl_pkg::I_TRIS][10:0]) begin
                    st_d = pmbfl_pkg::SEQ_ON;
                end
            end
            pmbfl_pkg::SEQ_ON: st_d = pmbfl_pkg::SEQ_ON;
        endcase
        if (!run_ok) begin
            st_d = pmbfl_pkg::SEQ_OFF;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= pmbfl_pkg::SEQ_OFF;
        end else begin
            st_q <= st_d;
        end
    end

    // Millisecond divider restarts on entry to delay or rise
    assign tick = div_q == 32'(MS_CYCLES - 1);
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_q <= 32'h0;
        end else if (st_d != st_q && st_d != pmbfl_pkg::SEQ_ON) begin
            div_q <= 32'h0;
        end else begin
            div_q <= tick ? 32'h0 : div_q + 32'h1;
        end
    end

    // Milliseconds spent in the current phase; saturates
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ms_q <= 11'h000;
        end else if (st_d != st_q) begin
            ms_q <= 11'h000;
        end else if (tick && ms_q != 11'h7FF) begin
            ms_q <= ms_q + 11'h001;
        end
    end

    // Timeout clock restarts at rise start; rising above the UV level blocks the fault
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ton_ms_q   <= 11'h000;
            reached_q  <= 1'b0;
            tmo_done_q <= 1'b0;
        end else if (st_d == pmbfl_pkg::SEQ_RISE &&
                     st_q != pmbfl_pkg::SEQ_RISE) begin
            ton_ms_q   <= 11'h000;
            reached_q  <= 1'b0;
            tmo_done_q <= 1'b0;
        end else begin
            if (tick && ton_ms_q != 11'h7FF) begin
                ton_ms_q <= ton_ms_q + 11'h001;
            end
            if (smp_valid && vout_w > uvf_s) begin
                reached_q <= 1'b1;
            end
            if (ev[4]) begin
                tmo_done_q <= 1'b1;
            end
        end
    end

    // Converter enable, ramp flag and power good, all registered
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            convert_en_q <= 1'b0;
            ramp_q       <= 1'b0;
            power_good_q <= 1'b0;
        end else begin
            convert_en_q <= st_d == pmbfl_pkg::SEQ_RISE ||
                            st_d == pmbfl_pkg::SEQ_ON;
            ramp_q       <= st_d == pmbfl_pkg::SEQ_RISE;
            if (st_d == pmbfl_pkg::SEQ_OFF) begin
                power_good_q <= 1'b0;
            end else if (smp_valid && vout_w <= pgof_s) begin
                power_good_q <= 1'b0;
            end else if (smp_valid && vout_w >= pgon_s &&
                         st_q != pmbfl_pkg::SEQ_DELAY) begin
                power_good_q <= 1'b1;
            end
        end
    end

    // Checks
    sequence s_clear;
        clr && ev == 5'h00;
    endsequence

    a_clear_faults: assert property (@(posedge clk) disable iff (!reset_n)
        s_clear |=> fault_q == 5'h00)
        else $error("faults survived a clear");
    a_fault_sticky: assert property (@(posedge clk) disable iff (!reset_n)
        !clr |=> (fault_q & $past(fault_q)) == $past(fault_q))
        else $error("latched fault dropped without clear");
    a_shut_stops: assert property (@(posedge clk) disable iff (!reset_n)
        shut_q |=> !convert_en_q [*2])
        else $error("converter ran while shut down");
    a_bad_exponent: assert property (@(posedge clk) disable iff (!reset_n)
        cmd_valid && cmd_write && cmd_code == pmbfl_pkg::CMD_OCF &&
        cmd_wdata[15:11] != pmbfl_pkg::EXP_M1
        |=> !rsp_ack_q && $stable(regs_q[pmbfl_pkg::I_OCF]))
        else $error("bad exponent accepted");
    // Only a well-formed write is owed an ack; sequencer must hold its state that cycle
    a_fall_no_effect: assert property (@(posedge clk) disable iff (!reset_n)
        cmd_valid && cmd_write && cmd_code == pmbfl_pkg::CMD_TOFFF &&
        cmd_wdata[15:11] == pmbfl_pkg::EXP_0 && st_d == st_q
        |=> rsp_ack_q && $stable(convert_en_q))
        else $error("fall time write misbehaved");
    a_delay_wait: assert property (@(posedge clk) disable iff (!reset_n)
        st_q == pmbfl_pkg::SEQ_DELAY && st_d == pmbfl_pkg::SEQ_RISE
        |-> ms_q >= regs_q[pmbfl_pkg::I_TDLY][10:0])
        else $error("rise began before delay ended");
    a_tmo_disabled: assert property (@(posedge clk) disable iff (!reset_n)
        regs_q[pmbfl_pkg::I_TMAX][10:0] == 11'h000 && !fault_q[4]
        |=> !fault_q[4])
        else $error("timeout fault with limit zero");
    a_uv_ignore: assert property (@(posedge clk) disable iff (!reset_n)
        ev == 5'h01 && !shut_mask[0] && !shut_q |=> !shut_q &&
        fault_q[0])
        else $error("ignored fault shut the converter");
    a_pg_negate: assert property (@(posedge clk) disable iff (!reset_n)
        smp_valid && vout_w <= pgof_s |=> !power_good_q)
        else $error("power good held below negate level");
endmodule

// File: testbench/pmbfl_host_model.sv
`timescale 1ns/1ps
// Host side of the command port, one command per call
module pmbfl_host_model (
    // Clock
    input  wire logic        clk,
    // Command port toward the device
    output logic             cmd_valid,
    output logic             cmd_write,
    output logic [7:0]       cmd_code,
    output logic [15:0]      cmd_wdata,
    input  wire logic        rsp_valid_q,
    input  wire logic        rsp_ack_q,
    input  wire logic [15:0] rsp_data_q
);
    // Idle until the first call
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code  = 8'h00;
        cmd_wdata = 16'h0000;
    end

    // Held over one rising edge; answer taken at the next falling edge
    task automatic xfer(input logic w, input logic [7:0] c,
        input logic [15:0] d, output logic v, output logic a,
        output logic [15:0] r);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_code  = c;
        cmd_wdata = d;
        @(negedge clk);
        cmd_valid = 1'b0;
        // Released qualifiers never keep the old value
        cmd_write = ~w;
        cmd_code  = ~c;
        cmd_wdata = ~d;
        v = rsp_valid_q;
        a = rsp_ack_q;
        r = rsp_data_q;
    endtask

    // Send-only command wiping every latched fault
    task automatic clear_faults(output logic v, output logic a);
        logic [15:0] r;
        xfer(1'b1, 8'h03, 16'h0000, v, a, r);
    endtask
endmodule

// File: testbench/tb_pmbus_fault_limit_sequencing.sv
`timescale 1ns/1ps
// Command, telemetry and start-up checks of the limit block
module tb_pmbus_fault_limit_sequencing;
    // Short millisecond keeps sequencing to tens of cycles
    localparam int MS = 10;
    localparam logic [7:0] DC [21] = '{8'h29, 8'h43, 8'h44, 8'h45,
        8'h46, 8'h47, 8'h4A, 8'h4F, 8'h50, 8'h51, 8'h55, 8'h56, 8'h58,
        8'h5E, 8'h5F, 8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65};
    localparam logic [15:0] DV [21] = '{16'hE808, 16'h0071, 16'h0065,
        16'h0000, 16'hF85C, 16'h0080, 16'hF84E, 16'h0091, 16'h00C0,
        16'h007D, 16'hF060, 16'h0080, 16'hF801, 16'h0073, 16'h006C,
        16'h0000, 16'h0002, 16'h0000, 16'h0000, 16'h0000, 16'h0001};
    // Benign telemetry: no warning, no fault
    localparam logic [15:0] VB = 16'h0080, IB = 16'h0010;
    localparam logic [15:0] TB = 16'h0010, NB = 16'h0020;
    logic        clk, reset_n, smp_valid, start_req, v, a;
    logic        cmd_valid, cmd_write, rsp_valid_q, rsp_ack_q;
    logic        convert_en_q, ramp_q, power_good_q;
    logic [7:0]  cmd_code;
    logic [15:0] cmd_wdata, rsp_data_q, r;
    logic [15:0] vout_smp, iout_smp, temp_smp, vin_smp;
    logic [3:0]  warn_q;
    logic [4:0]  fault_q;
    int          fail_count, cmp_count, n;

    pmbfl_limits #(.MS_CYCLES(MS)) pmbfl_limits_i (.clk(clk),
        .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
        .rsp_valid_q(rsp_valid_q), .rsp_ack_q(rsp_ack_q),
        .rsp_data_q(rsp_data_q), .smp_valid(smp_valid),
        .vout_smp(vout_smp), .iout_smp(iout_smp), .temp_smp(temp_smp),
        .vin_smp(vin_smp), .start_req(start_req),
        .convert_en_q(convert_en_q), .ramp_q(ramp_q),
        .power_good_q(power_good_q), .warn_q(warn_q), .fault_q(fault_q));
    pmbfl_host_model pmbfl_host_model_i (.clk(clk),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
        .rsp_valid_q(rsp_valid_q), .rsp_ack_q(rsp_ack_q),
        .rsp_data_q(rsp_data_q));

    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string s, input logic [15:0] e,
        input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s exp %h got %h", s, e, g);
        end
    endtask
    // Exhausted wait counts and ends the run
    task automatic tmo();
        if (n >= 200) begin
            fail_count++;
            conclude();
        end
    endtask
    task automatic cmd(input logic w, input logic [7:0] c,
        input logic [15:0] d, input logic ea, input logic [15:0] ed);
        pmbfl_host_model_i.xfer(w, c, d, v, a, r);
        chk("rsp_valid", 16'h0001, {15'h0, v});
        chk("rsp_ack", {15'h0, ea}, {15'h0, a});
        chk("rsp_data", ed, r);
    endtask
    task automatic smp(input logic [15:0] vo, io, te, vi);
        @(negedge clk);
        smp_valid = 1'b1;
        vout_smp = vo;
        iout_smp = io;
        temp_smp = te;
        vin_smp = vi;
        @(negedge clk);
        smp_valid = 1'b0;
    endtask
    task automatic st(input logic [3:0] w, input logic [4:0] f);
        chk("warn", {12'h0, w}, {12'h0, warn_q});
        chk("fault", {11'h0, f}, {11'h0, fault_q});
    endtask
    task automatic clr();
        pmbfl_host_model_i.clear_faults(v, a);
        chk("clear_ack", 16'h0001, {15'h0, a});
        chk("fault", 16'h0000, {11'h0, fault_q});
    endtask
    task automatic bit1(input string s, input logic e, input logic g);
        chk(s, {15'h0, e}, {15'h0, g});
    endtask

    initial begin
        {reset_n, smp_valid, start_req} = 3'h0;
        {vout_smp, iout_smp, temp_smp, vin_smp} = {VB, IB, TB, NB};
        fail_count = 0;
        cmp_count = 0;
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        repeat (2) @(negedge clk);
        // Reset values of the whole set
        for (int i = 0; i < 21; i++) begin
            cmd(1'b0, DC[i], 16'h0, 1'b1, DV[i]);
        end
        // Exponent policing, inert timing registers, unknown code
        cmd(1'b1, 8'h46, 16'hF850, 1'b1, 16'h0);
        cmd(1'b1, 8'h46, 16'h0850, 1'b0, 16'h0);
        cmd(1'b0, 8'h46, 16'h0, 1'b1, 16'hF850);
        cmd(1'b1, 8'h55, 16'hF860, 1'b0, 16'h0);
        cmd(1'b1, 8'h4F, 16'hF891, 1'b0, 16'h0);
        cmd(1'b1, 8'h29, 16'hE803, 1'b0, 16'h0);
        cmd(1'b1, 8'h65, 16'h0005, 1'b1, 16'h0);
        cmd(1'b1, 8'h64, 16'h0007, 1'b1, 16'h0);
        cmd(1'b0, 8'h64, 16'h0, 1'b1, 16'h0007);
        cmd(1'b0, 8'h65, 16'h0, 1'b1, 16'h0005);
        cmd(1'b0, 8'h30, 16'h0, 1'b0, 16'h0);
        cmd(1'b1, 8'h60, 16'h0002, 1'b1, 16'h0);
        // Start: 2 ms delay, then 2 ms rise
        start_req = 1'b1;
        n = 0;
        while (ramp_q !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        tmo();
        bit1("delay", 1'b1, n >= 19 && n <= 23);
        n = 0;
        while (ramp_q === 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        tmo();
        bit1("rise", 1'b1, n >= 19 && n <= 23);
        bit1("convert", 1'b1, convert_en_q);
        // Power good hysteresis, low warning, ignored under-voltage
        smp(16'h0073, IB, TB, NB);
        bit1("pgood", 1'b1, power_good_q);
        smp(16'h0070, IB, TB, NB);
        bit1("pgood", 1'b1, power_good_q);
        st(4'h1, 5'h00);
        smp(16'h006C, IB, TB, NB);
        bit1("pgood", 1'b0, power_good_q);
        smp(16'h0065, IB, TB, NB);
        st(4'h1, 5'h01);
        bit1("convert", 1'b1, convert_en_q);
        // Over-current warning then fault with shutdown
        smp(VB, 16'h004E, TB, NB);
        st(4'h2, 5'h01);
        smp(VB, 16'h0050, TB, NB);
        st(4'h2, 5'h03);
        @(negedge clk);
        bit1("convert", 1'b0, convert_en_q);
        clr();
        // Restart, then temperature and input checks
        start_req = 1'b0;
        @(negedge clk);
        start_req = 1'b1;
        n = 0;
        while (convert_en_q !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        tmo();
        smp(VB, IB, 16'h007D, NB);
        st(4'h4, 5'h00);
        smp(VB, IB, 16'h0091, NB);
        st(4'h4, 5'h04);
        @(negedge clk);
        bit1("convert", 1'b0, convert_en_q);
        smp(VB, IB, TB, 16'h0002);
        st(4'h8, 5'h04);
        smp(VB, IB, TB, 16'h0060);
        st(4'h0, 5'h0C);
        // Turn-on timeout of 3 ms with ignore action
        start_req = 1'b0;
        cmd(1'b1, 8'h60, 16'h0000, 1'b1, 16'h0);
        cmd(1'b1, 8'h62, 16'h0003, 1'b1, 16'h0);
        clr();
        start_req = 1'b1;
        n = 0;
        while (fault_q[4] !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        tmo();
        bit1("timeout", 1'b1, n >= 29 && n <= 34);
        bit1("convert", 1'b1, convert_en_q);
        // Half loop scale doubles the output levels
        cmd(1'b1, 8'h29, 16'hE804, 1'b1, 16'h0);
        smp(16'h00E2, IB, TB, NB);
        st(4'h1, 5'h10);
        smp(16'h00E3, IB, TB, NB);
        st(4'h0, 5'h10);
        // Mid-run reset drops faults and restores defaults
        start_req = 1'b0;
        reset_n = 1'b0;
        @(negedge clk);
        reset_n = 1'b1;
        @(negedge clk);
        st(4'h0, 5'h00);
        bit1("convert", 1'b0, convert_en_q);
        cmd(1'b0, 8'h29, 16'h0, 1'b1, 16'hE808);
        cmd(1'b0, 8'h46, 16'h0, 1'b1, 16'hF85C);
        conclude();
    end
endmodule
